// file: testbench/tb_top.sv
// Self-checking bench for the comparator reference control block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ref_ctrl_pkg::ADDR_W-1:0] addr = '0;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [2:0] nsel = 3'h0;
  logic [5:0] csel = 6'h00;
  logic [15:0] rdata;
  logic pwr, oe, sup, path;
  logic [4:0] code;
  logic [1:0] src;
  logic [5:0] nroute, iroute;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [15:0] ctl;
  logic [31:0] rn;
  logic rd_d = 1'b0;

  // ----------------------------------------------------------------
  // Clock, design and monitors
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  comparator_reference_control #(.NUM_CMP(3)) i_dut (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .noninv_internal_select(nsel), .inverting_channel_select(csel),
    .ladder_power_on(pwr), .ladder_pin_output_enable(oe), .ladder_supply_select(sup),
    .ladder_level_code(code), .ext_pos_path_select(path), .gap_or_ext_source_select(src),
    .noninv_route(nroute), .inv_route(iroute));

  // Compares one value and counts the outcome.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Remembers which cycle carries read data and cuts a hang short.
  always @(posedge clk) begin
    rd_d <= rd_en & ~srst;
    cycles++;
    if (cycles > 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  // Takes the oldest expected read off the queue when read data stand.
  always @(negedge clk) begin
    if (!srst) begin
      if (rd_d) begin
        e = exp_q.pop_front();
        check(rdata, e, "read data");
      end else begin
        check(rdata, 16'h0000, "idle read data");
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a; wdata <= d; wr_en <= 1'b1; rd_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    addr <= a; rd_en <= 1'b1; wr_en <= 1'b0; exp_q.push_back(exp);
    @(posedge clk);
  endtask

  task automatic idle();
    wr_en <= 1'b0; rd_en <= 1'b0;
    @(posedge clk);
  endtask

  // Expected inverting routes in the upper half and noninverting routes in the lower half.
  function automatic logic [11:0] routes(logic [15:0] c, logic [2:0] n, logic [5:0] h);
    logic [11:0] r;
    r = 12'h000;
    for (int i = 0; i < 3; i++) begin
      r[2*i+:2] = !n[i] ? 2'h0 : (c[10] ? 2'h2 : 2'h1);
      r[6+2*i+:2] = (h[2*i+:2] != 2'h3) ? 2'h0 : (c[9:8] == 2'h0) ? 2'h1 :
                    (c[9:8] == 2'h3) ? 2'h2 : 2'h3;
    end
    return r;
  endfunction

  // Checks every control output and route, then returns on a rising edge for the next driver.
  task automatic check_outputs();
    @(negedge clk);
    check({5'h00, pwr, oe, sup, code, path, src},
          {5'h00, ctl[7], ctl[6], ctl[5], ctl[4:0], ctl[10], ctl[9:8]}, "controls");
    check({4'h0, iroute, nroute}, {4'h0, routes(ctl, nsel, csel)}, "routes");
    @(posedge clk);
  endtask

  // Writes control, tries an ignored write, reads back three places and checks outputs.
  task automatic apply(input logic [15:0] w, input logic [2:0] n, input logic [5:0] h,
                       input logic [3:0] ua);
    ctl = w & ref_ctrl_pkg::CONTROL_IMPL_MASK;
    nsel <= n; csel <= h;
    wr(ref_ctrl_pkg::OFF_CONTROL, w);
    wr(ref_ctrl_pkg::OFF_STATUS, ~w);
    rd(ref_ctrl_pkg::OFF_CONTROL, ctl);
    rd(ref_ctrl_pkg::OFF_STATUS, {8'h00, ctl[7], ctl[6], 1'b0, ctl[4:0]});
    rd(ua | 4'h2, 16'h0000);
    idle();
    check_outputs();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(12));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    ctl = 16'h0000;
    idle();
    check_outputs();
    // Every path and source code with all comparators on the internal reference.
    for (int s = 0; s < 8; s++) apply({5'h1f, s[2:0], 8'hff}, 3'h7, 6'h3f, 4'h3);
    // Every ladder code in both supply ranges.
    for (int c = 0; c < 64; c++) apply({10'h000, c[5:0]} | 16'h00c0, 3'h5, 6'h33, 4'hf);
    // Random words, selects and unmapped addresses.
    repeat (40) begin
      rn = $urandom;
      apply(rn[15:0], rn[18:16], rn[24:19], rn[28:25]);
    end
    // A second reset in mid-run clears everything.
    apply(16'hffff, 3'h7, 6'h3f, 4'h9);
    srst <= 1'b1;
    idle();
    idle();
    srst <= 1'b0;
    ctl = 16'h0000;
    idle();
    check_outputs();
    rd(ref_ctrl_pkg::OFF_CONTROL, 16'h0000);
    idle();
    idle();
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: verilog/comparator_reference_control.sv
// Top of the comparator reference control: register port, ladder controls and routes.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module comparator_reference_control #(
  parameter int NUM_CMP = 3
) (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [ref_ctrl_pkg::ADDR_W-1:0] addr, // Register address.
  input wire logic [15:0] wdata, // Write data.
  input wire logic wr_en, // Write strobe.
  input wire logic rd_en, // Read strobe.
  output logic [15:0] rdata, // Read data, valid the cycle after rd_en.
  input wire logic [NUM_CMP-1:0] noninv_internal_select, // Comparator noninverting selects.
  input wire logic [2*NUM_CMP-1:0] inverting_channel_select, // Comparator channel selects.
  output logic ladder_power_on, // Ladder powered.
  output logic ladder_pin_output_enable, // Level driven on its pin.
  output logic ladder_supply_select, // 1: external rails, 0: analogue supply.
  output logic [ref_ctrl_pkg::CODE_W-1:0] ladder_level_code, // Ladder tap code.
  output logic ext_pos_path_select, // Path select to comparators.
  output logic [1:0] gap_or_ext_source_select, // Inverting source field.
  output logic [2*NUM_CMP-1:0] noninv_route, // Noninverting route per comparator.
  output logic [2*NUM_CMP-1:0] inv_route // Inverting route per comparator.
);
  if (NUM_CMP < 1 || NUM_CMP > 8) begin : g_bad_num
    $error("NUM_CMP must be 1 to 8");
  end
  localparam int LAST_CODE = ref_ctrl_pkg::LEVELS - 1;
  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [15:0] control_q;
  logic [15:0] control_d;
  logic [15:0] rdata_d;
  logic [15:0] status_w;
  // Only implemented bits take write data; the upper five stay zero.
  always_comb begin
    control_d = control_q;
    if (wr_en && addr == ref_ctrl_pkg::OFF_CONTROL) begin
      control_d = wdata & ref_ctrl_pkg::CONTROL_IMPL_MASK;
    end
  end
  // Register update; all implemented bits clear on reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      control_q <= ref_ctrl_pkg::CONTROL_RESET;
    end else begin
      control_q <= control_d;
    end
  end
  // ----------------------------------------------------------------
  // Analogue control outputs
  // ----------------------------------------------------------------
  // Outputs are flops loaded from the next register value, so they change on the write edge.
  always_ff @(posedge clk) begin
    if (srst) begin
      ladder_power_on <= 1'b0;
      ladder_pin_output_enable <= 1'b0;
      ladder_supply_select <= 1'b0;
      ladder_level_code <= '0;
      ext_pos_path_select <= 1'b0;
      gap_or_ext_source_select <= 2'h0;
    end else begin
      ladder_power_on <= control_d[ref_ctrl_pkg::POS_POWER];
      ladder_pin_output_enable <= control_d[ref_ctrl_pkg::POS_PIN_OE];
      ladder_supply_select <= control_d[ref_ctrl_pkg::POS_SUPPLY_SEL];
      // The code selects one of 32 taps; the analogue ladder forms low + code/32 * span.
      ladder_level_code <= control_d[ref_ctrl_pkg::POS_CODE_HI:ref_ctrl_pkg::POS_CODE_LO];
      ext_pos_path_select <= control_d[ref_ctrl_pkg::POS_PATH_SEL];
      gap_or_ext_source_select <= control_d[ref_ctrl_pkg::POS_SRC_HI:ref_ctrl_pkg::POS_SRC_LO];
    end
  end
  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Status shows the live power, pin enable and code as driven to the ladder.
  assign status_w = {8'h00, ladder_power_on, ladder_pin_output_enable, 1'b0, ladder_level_code};
  always_comb begin
    rdata_d = 16'h0000;
    if (addr == ref_ctrl_pkg::OFF_CONTROL) begin
      rdata_d = control_q;
    end else if (addr == ref_ctrl_pkg::OFF_STATUS) begin
      rdata_d = status_w;
    end
  end
  // Read data stand for one cycle after the strobe and return to zero otherwise.
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else if (rd_en) begin
      rdata <= rdata_d;
    end else begin
      rdata <= 16'h0000;
    end
  end
  // ----------------------------------------------------------------
  // Comparator routing
  // ----------------------------------------------------------------
  ref_ctrl_if ctrl_bus ();
  assign ctrl_bus.path_sel = ext_pos_path_select;
  assign ctrl_bus.src_sel = gap_or_ext_source_select;
  comparator_route #(.NUM_CMP(NUM_CMP)) u_route (
    .clk(clk),
    .srst(srst),
    .ctrl(ctrl_bus.sink),
    .noninv_internal_select(noninv_internal_select),
    .inverting_channel_select(inverting_channel_select),
    .noninv_route(noninv_route),
    .inv_route(inv_route)
  );
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_upper_zero: assert property (@(posedge clk) disable iff (srst)
    control_q[15:11] == 5'h00) else $error("unimplemented bits set");
  a_code_follows: assert property (@(posedge clk) disable iff (srst)
    wr_en && addr == ref_ctrl_pkg::OFF_CONTROL |=> ladder_level_code == $past(wdata[4:0]))
    else $error("level code did not follow write");
  a_code_range: assert property (@(posedge clk) disable iff (srst)
    int'(ladder_level_code) <= LAST_CODE && ladder_level_code == control_q[4:0])
    else $error("code out of range");
  a_power_bit: assert property (@(posedge clk) disable iff (srst)
    wr_en && addr == ref_ctrl_pkg::OFF_CONTROL |=> ladder_power_on == $past(wdata[7]))
    else $error("power bit wrong");
  a_pin_enable: assert property (@(posedge clk) disable iff (srst)
    ladder_pin_output_enable == control_q[6]) else $error("pin enable mismatch");
  a_supply_sel: assert property (@(posedge clk) disable iff (srst)
    ladder_supply_select == control_q[5]) else $error("supply select mismatch");
  a_hold_idle: assert property (@(posedge clk) disable iff (srst)
    !wr_en |=> $stable(control_q)) else $error("register changed without write");
  a_read_data: assert property (@(posedge clk) disable iff (srst)
    rd_en && addr == ref_ctrl_pkg::OFF_CONTROL |=> rdata == $past(control_q))
    else $error("read data wrong");
  a_noninv_path: assert property (@(posedge clk) disable iff (srst)
    noninv_internal_select[0] && ext_pos_path_select |=> noninv_route[1:0] == 2'b10)
    else $error("noninverting route wrong");
  a_noninv_pin: assert property (@(posedge clk) disable iff (srst)
    !noninv_internal_select[0] |=> noninv_route[1:0] == 2'b00)
    else $error("noninverting pin route wrong");
  a_inv_gap: assert property (@(posedge clk) disable iff (srst)
    inverting_channel_select[1:0] == 2'h3 && gap_or_ext_source_select == 2'h0
    |=> inv_route[1:0] == 2'b01) else $error("band gap route wrong");
  // Each control field follows a write to the control register on the next edge.
  a_supply_follows: assert property (@(posedge clk) disable iff (srst)
    wr_en && addr == ref_ctrl_pkg::OFF_CONTROL |=> ladder_supply_select == $past(wdata[5]))
    else $error("supply select did not follow write");
  a_pin_follows: assert property (@(posedge clk) disable iff (srst)
    wr_en && addr == ref_ctrl_pkg::OFF_CONTROL |=> ladder_pin_output_enable == $past(wdata[6]))
    else $error("pin enable did not follow write");
  a_path_follows: assert property (@(posedge clk) disable iff (srst)
    wr_en && addr == ref_ctrl_pkg::OFF_CONTROL |=> ext_pos_path_select == $past(wdata[10]))
    else $error("path select did not follow write");
  a_src_follows: assert property (@(posedge clk) disable iff (srst)
    wr_en && addr == ref_ctrl_pkg::OFF_CONTROL |=> gap_or_ext_source_select == $past(wdata[9:8]))
    else $error("source field did not follow write");
  // Writes to any other address leave the control register alone.
  a_other_write: assert property (@(posedge clk) disable iff (srst)
    wr_en && addr != ref_ctrl_pkg::OFF_CONTROL |=> $stable(control_q))
    else $error("write to another address changed control");
  // Read data are zero when idle, the live outputs for status and zero when unmapped.
  a_read_idle: assert property (@(posedge clk) disable iff (srst)
    !rd_en |=> rdata == 16'h0000) else $error("read data not zero when idle");
  a_read_status: assert property (@(posedge clk) disable iff (srst)
    rd_en && addr == ref_ctrl_pkg::OFF_STATUS |=> rdata == {8'h00, $past(ladder_power_on),
    $past(ladder_pin_output_enable), 1'b0, $past(ladder_level_code)})
    else $error("status read wrong");
  a_read_unmapped: assert property (@(posedge clk) disable iff (srst)
    rd_en && addr != ref_ctrl_pkg::OFF_CONTROL && addr != ref_ctrl_pkg::OFF_STATUS
    |=> rdata == 16'h0000) else $error("unmapped read not zero");
  // Reset clears the register, the read data, the ladder power, the pin enable and the level code.
  a_reset_clear: assert property (@(posedge clk)
    srst |=> control_q == ref_ctrl_pkg::CONTROL_RESET && !ladder_power_on
    && !ladder_pin_output_enable && ladder_level_code == 5'h00 && rdata == 16'h0000)
    else $error("reset did not clear controls");
  // ----------------------------------------------------------------
  // Per-comparator route checks
  // ----------------------------------------------------------------
  // Every comparator's routes follow its own selects one edge later.
  for (genvar i = 0; i < NUM_CMP; i++) begin : g_route_chk
    a_route_pin: assert property (@(posedge clk) disable iff (srst)
      !noninv_internal_select[i] |=> noninv_route[2*i+:2] == ref_ctrl_pkg::NONINV_PIN)
      else $error("noninverting input not on its pin");
    a_route_ladder: assert property (@(posedge clk) disable iff (srst)
      noninv_internal_select[i] && !ext_pos_path_select
      |=> noninv_route[2*i+:2] == ref_ctrl_pkg::NONINV_LADDER)
      else $error("noninverting input not on the ladder");
    a_route_ext: assert property (@(posedge clk) disable iff (srst)
      noninv_internal_select[i] && ext_pos_path_select
      |=> noninv_route[2*i+:2] == ref_ctrl_pkg::NONINV_EXT_POS)
      else $error("noninverting input not on the external pin");
    a_inv_chan_pin: assert property (@(posedge clk) disable iff (srst)
      inverting_channel_select[2*i+:2] != ref_ctrl_pkg::CH_INTERNAL
      |=> inv_route[2*i+:2] == ref_ctrl_pkg::INV_PIN)
      else $error("inverting input not on its pin");
    a_inv_band_gap: assert property (@(posedge clk) disable iff (srst)
      inverting_channel_select[2*i+:2] == ref_ctrl_pkg::CH_INTERNAL
      && gap_or_ext_source_select == ref_ctrl_pkg::SRC_BANDGAP
      |=> inv_route[2*i+:2] == ref_ctrl_pkg::INV_BANDGAP)
      else $error("inverting input not on the band gap");
    a_inv_ext_pos: assert property (@(posedge clk) disable iff (srst)
      inverting_channel_select[2*i+:2] == ref_ctrl_pkg::CH_INTERNAL
      && gap_or_ext_source_select == ref_ctrl_pkg::SRC_EXT_POS
      |=> inv_route[2*i+:2] == ref_ctrl_pkg::INV_EXT_POS)
      else $error("inverting input not on the external pin");
    a_inv_reserved: assert property (@(posedge clk) disable iff (srst)
      inverting_channel_select[2*i+:2] == ref_ctrl_pkg::CH_INTERNAL
      && gap_or_ext_source_select inside {2'h1, 2'h2}
      |=> inv_route[2*i+:2] == ref_ctrl_pkg::INV_NONE)
      else $error("reserved source code routed something");
  end
  c_write_ctrl: cover property (@(posedge clk) wr_en && addr == ref_ctrl_pkg::OFF_CONTROL);
  c_ladder_on: cover property (@(posedge clk) ladder_power_on && ladder_pin_output_enable);
  c_ext_route: cover property (@(posedge clk) inv_route[1:0] == 2'b10);
  c_read_status: cover property (@(posedge clk) rd_en && addr == ref_ctrl_pkg::OFF_STATUS);
  c_reserved_src: cover property (@(posedge clk) inv_route[1:0] == 2'h3);
endmodule
`default_nettype wire

// file: verilog/comparator_route.sv
// Route decoder that turns comparator selects and reference controls into input routes.
`timescale 1ns/1ns
`default_nettype none
module comparator_route #(
  parameter int NUM_CMP = 3
) (
  input wire logic clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  ref_ctrl_if.sink ctrl, // Registered reference controls.
  input wire logic [NUM_CMP-1:0] noninv_internal_select, // Per-comparator noninverting select.
  input wire logic [2*NUM_CMP-1:0] inverting_channel_select, // Per-comparator channel select.
  output logic [2*NUM_CMP-1:0] noninv_route, // Noninverting route per comparator.
  output logic [2*NUM_CMP-1:0] inv_route // Inverting route per comparator.
);
  // ----------------------------------------------------------------
  // Per-comparator route decode
  // ----------------------------------------------------------------
  // Reserved source codes route nothing, so the inverting input floats off the bus.
  function automatic logic [1:0] inv_decode(input logic [1:0] ch, input logic [1:0] src);
    if (ch != ref_ctrl_pkg::CH_INTERNAL) begin
      inv_decode = ref_ctrl_pkg::INV_PIN;
    end else if (src == ref_ctrl_pkg::SRC_BANDGAP) begin
      inv_decode = ref_ctrl_pkg::INV_BANDGAP;
    end else if (src == ref_ctrl_pkg::SRC_EXT_POS) begin
      inv_decode = ref_ctrl_pkg::INV_EXT_POS;
    end else begin
      inv_decode = ref_ctrl_pkg::INV_NONE;
    end
  endfunction
  for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
    // Noninverting input takes the internal reference only when selected.
    always_ff @(posedge clk) begin
      if (srst) begin
        noninv_route[2*i+:2] <= ref_ctrl_pkg::NONINV_PIN;
      end else if (!noninv_internal_select[i]) begin
        noninv_route[2*i+:2] <= ref_ctrl_pkg::NONINV_PIN;
      end else if (ctrl.path_sel) begin
        noninv_route[2*i+:2] <= ref_ctrl_pkg::NONINV_EXT_POS;
      end else begin
        noninv_route[2*i+:2] <= ref_ctrl_pkg::NONINV_LADDER;
      end
    end
    // Inverting input follows the channel select and the source field.
    always_ff @(posedge clk) begin
      if (srst) begin
        inv_route[2*i+:2] <= ref_ctrl_pkg::INV_PIN;
      end else begin
        inv_route[2*i+:2] <= inv_decode(inverting_channel_select[2*i+:2], ctrl.src_sel);
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/ref_ctrl_if.sv
// Interface carrying the decoded reference controls between the register file and the router.
`timescale 1ns/1ns
`default_nettype none
interface ref_ctrl_if;
  logic path_sel;
  logic [1:0] src_sel;
  modport source (output path_sel, output src_sel);
  modport sink (input path_sel, input src_sel);
endinterface
`default_nettype wire

// file: verilog/ref_ctrl_pkg.sv
// Package with register layout, reset values and route encodings of the reference control.
package ref_ctrl_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_IMPL_MASK = 16'h07ff;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_CODE_LO = 0;
  localparam int POS_CODE_HI = 4;
  localparam int POS_SUPPLY_SEL = 5;
  localparam int POS_PIN_OE = 6;
  localparam int POS_POWER = 7;
  localparam int POS_SRC_LO = 8;
  localparam int POS_SRC_HI = 9;
  localparam int POS_PATH_SEL = 10;
  localparam int CODE_W = 5;
  localparam int LEVELS = 32;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_BANDGAP = 2'h0;
  localparam logic [1:0] SRC_EXT_POS = 2'h3;
  localparam logic [1:0] CH_INTERNAL = 2'h3;
  typedef enum logic [1:0] {
    NONINV_PIN = 2'b00,
    NONINV_LADDER = 2'b01,
    NONINV_EXT_POS = 2'b10
  } noninv_route_e;
  typedef enum logic [1:0] {
    INV_PIN = 2'b00,
    INV_BANDGAP = 2'b01,
    INV_EXT_POS = 2'b10,
    INV_NONE = 2'b11
  } inv_route_e;
endpackage
